// ---- core/pfph_pkg.sv ----
// package of constants and types for the parallel flash programming handshake
package pfph_pkg;
    // ====================
    // bus widths and read fifo depth
    localparam int DATA_W = 16;
    localparam int MODE_W = 4;
    localparam int FIFO_DEPTH = 4;
    // ====================
    // mode encodings (read vs write command)
    localparam logic [3:0] MODE_READ = 4'h1;
    // ====================
    // reset values of the handshake pins on both ends
    localparam logic RDY_RST = 1'b1;
    localparam logic VALID_N_RST = 1'b1;
    localparam logic CMD_N_RST = 1'b1;
    localparam logic OE_N_RST = 1'b1;
    localparam logic [15:0] DATA_RST = 16'h0000;
    // ====================
    // device handshake states
    typedef enum logic [2:0] {
        PFPH_D_IDLE,
        PFPH_D_EXEC,
        PFPH_D_WAIT_OE_LO,
        PFPH_D_DRIVE,
        PFPH_D_VALID,
        PFPH_D_RELEASE,
        PFPH_D_WAIT_CMD_HI
    } pfph_dev_state_t;
    // programmer handshake states
    typedef enum logic [3:0] {
        PFPH_P_IDLE,
        PFPH_P_SETUP,
        PFPH_P_CMD_LO,
        PFPH_P_WAIT_RDY_LO,
        PFPH_P_OE_LO,
        PFPH_P_WAIT_VALID_LO,
        PFPH_P_OE_HI,
        PFPH_P_WAIT_VALID_HI,
        PFPH_P_CMD_HI,
        PFPH_P_WAIT_RDY_HI
    } pfph_prg_state_t;
endpackage : pfph_pkg

// ---- core/pfph_if.sv ----
// pin-level interface between programmer and device
`timescale 1ns/100ps
`default_nettype none
interface pfph_if;
    import pfph_pkg::*;
    logic              command_strobe_n;
    logic              output_enable_n;
    logic              data_valid_n;
    logic              rdy;
    logic [MODE_W-1:0] mode;
    logic [DATA_W-1:0] prg_data_o;
    logic              prg_data_oe;
    logic [DATA_W-1:0] dev_data_o;
    logic              dev_data_oe;
    logic [DATA_W-1:0] data_bus;
    // wire resolution; contention shows as x, an idle bus reads all ones
    assign data_bus = (prg_data_oe && dev_data_oe) ? {DATA_W{1'bx}} :
                      prg_data_oe ? prg_data_o :
                      dev_data_oe ? dev_data_o : {DATA_W{1'b1}};
    modport device (
        input  command_strobe_n, output_enable_n, mode, data_bus,
        output data_valid_n, rdy, dev_data_o, dev_data_oe
    );
    modport programmer (
        input  data_valid_n, rdy, data_bus,
        output command_strobe_n, output_enable_n, mode, prg_data_o, prg_data_oe
    );
endinterface : pfph_if
`default_nettype wire

// ---- core/pfph_fifo.sv ----
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pfph_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;
    // ====================
    // pointer and count update
    always_comb begin
        push    = in_valid && in_ready;
        pop     = out_valid && out_ready;
        nxt_wr  = push ? AW'((wr_ff == AW'(DEPTH - 1)) ? 0 : wr_ff + 1'b1) : wr_ff;
        nxt_rd  = pop ? AW'((rd_ff == AW'(DEPTH - 1)) ? 0 : rd_ff + 1'b1) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
    // storage, written by index
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end
    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
endmodule : pfph_fifo
`default_nettype wire

// ---- core/pfph_device.sv ----
// device end of the parallel flash programming handshake
// Functional notes
// - write: command latched, data bus stays input
// - write finishes when strobe returns high
// - read: latch mode/data on strobe low, drop ready
// - programmer tristates before output enable low
// - output enable low: drive flash contents
// - then pull data-valid strobe low
// - programmer samples, then raises output enable
// - output enable high: release bus, raise valid
// - programmer waits valid high before driving
// - programmer raises command strobe, bus left undriven
`timescale 1ns/100ps
`default_nettype none
module pfph_device
    import pfph_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    pfph_if.device                 pins,
    // user side: latched command
    output logic                   cmd_valid,
    output logic      [MODE_W-1:0] cmd_mode,
    output logic      [DATA_W-1:0] cmd_data,
    input  wire logic              cmd_done,
    // user side: read data into the fifo
    input  wire logic              rd_valid,
    output logic                   rd_ready,
    input  wire logic [DATA_W-1:0] rd_data
);
    // ====================
    // state and registered pin levels
    pfph_dev_state_t   st_ff, nxt_st;
    logic              rdy_ff, nxt_rdy;
    logic              valid_n_ff, nxt_valid_n;
    logic              oe_ff, nxt_oe;

    // latched command and outgoing read word
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic [MODE_W-1:0] mode_ff, nxt_mode;
    logic [DATA_W-1:0] din_ff, nxt_din;

    // synchroniser stages and settled levels
    logic [1:0]        cmd_sync_ff, oe_sync_ff;
    logic              cmd_lo, oe_lo;

    // fifo read side
    logic              q_valid, q_ready;
    logic [DATA_W-1:0] q_data;

    // ====================
    // mode decode
    function automatic logic is_read(input logic [MODE_W-1:0] m);
        return (m == MODE_READ);
    endfunction : is_read

    // ====================
    // synchronisers
    // two-flop sync
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_sync_ff <= {CMD_N_RST, CMD_N_RST};
            oe_sync_ff  <= {OE_N_RST, OE_N_RST};
        end else begin
            cmd_sync_ff <= {cmd_sync_ff[0], pins.command_strobe_n};
            oe_sync_ff  <= {oe_sync_ff[0], pins.output_enable_n};
        end
    end

    // only the second stage is read, never the first
    assign cmd_lo = !cmd_sync_ff[1];
    assign oe_lo  = !oe_sync_ff[1];

    // ====================
    // read data buffer
    // one word is popped per read, in the drive step
    pfph_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .nrst      (nrst),
        .in_valid  (rd_valid),
        .in_ready  (rd_ready),
        .in_data   (rd_data),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    // ====================
    // handshake state machine
    always_comb begin
        // hold everything unless a step moves it
        nxt_st      = st_ff;
        nxt_rdy     = rdy_ff;
        nxt_valid_n = valid_n_ff;
        nxt_oe      = oe_ff;
        nxt_dout    = dout_ff;
        nxt_mode    = mode_ff;
        nxt_din     = din_ff;
        q_ready     = 1'b0;
        case (st_ff)
            PFPH_D_IDLE: begin
                // programmer set mode and data before the strobe
                // latch and drop ready
                if (cmd_lo) begin
                    nxt_mode = pins.mode;
                    nxt_din  = pins.data_bus;
                    nxt_rdy  = 1'b0;
                    nxt_st   = is_read(pins.mode) ? PFPH_D_WAIT_OE_LO : PFPH_D_EXEC;
                end
            end

            PFPH_D_EXEC: begin
                // user logic runs the write until done
                // execute, bus stays input
                if (cmd_done) begin
                    nxt_st = PFPH_D_WAIT_CMD_HI;
                end
            end

            PFPH_D_WAIT_OE_LO: begin
                // bus turns round only after the enable
                // wait for programmer's enable
                if (oe_lo) begin
                    nxt_st = PFPH_D_DRIVE;
                end
            end

            PFPH_D_DRIVE: begin
                // an empty fifo stalls the read here
                // drive flash contents once available
                if (q_valid) begin
                    q_ready  = 1'b1;
                    nxt_dout = q_data;
                    nxt_oe   = 1'b1;
                    nxt_st   = PFPH_D_VALID;
                end
            end

            PFPH_D_VALID: begin
                // valid follows a cycle after the data
                // data stands one cycle before strobe
                nxt_valid_n = 1'b0;
                // programmer has sampled once enable is high
                // enable high releases bus
                if (!valid_n_ff && !oe_lo) begin
                    nxt_oe = 1'b0;
                    nxt_st = PFPH_D_RELEASE;
                end
            end

            PFPH_D_RELEASE: begin
                // bus already released, valid returns high
                // valid rises after bus released
                nxt_valid_n = 1'b1;
                nxt_st      = PFPH_D_WAIT_CMD_HI;
            end

            PFPH_D_WAIT_CMD_HI: begin
                // shared close of reads and writes
                // ready on strobe high
                if (!cmd_lo) begin
                    nxt_rdy = 1'b1;
                    nxt_st  = PFPH_D_IDLE;
                end
            end

            default: begin
                // unused codes fall back to idle
                nxt_st = PFPH_D_IDLE;
            end
        endcase
    end

    // register the next values
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff      <= PFPH_D_IDLE;
            rdy_ff     <= RDY_RST;
            valid_n_ff <= VALID_N_RST;
            oe_ff      <= 1'b0;
            dout_ff    <= DATA_RST;
            mode_ff    <= '0;
            din_ff     <= DATA_RST;
        end else begin
            st_ff      <= nxt_st;
            rdy_ff     <= nxt_rdy;
            valid_n_ff <= nxt_valid_n;
            oe_ff      <= nxt_oe;
            dout_ff    <= nxt_dout;
            mode_ff    <= nxt_mode;
            din_ff     <= nxt_din;
        end
    end

    // ====================
    // pin outputs
    assign pins.rdy          = rdy_ff;
    assign pins.data_valid_n = valid_n_ff;
    assign pins.dev_data_oe  = oe_ff;
    assign pins.dev_data_o   = dout_ff;

    // user side outputs
    assign cmd_valid         = (st_ff == PFPH_D_EXEC);
    assign cmd_mode          = mode_ff;
    assign cmd_data          = din_ff;

endmodule : pfph_device
`default_nettype wire

// ---- core/pfph_programmer.sv ----
// programmer end of the parallel flash programming handshake
`timescale 1ns/100ps
`default_nettype none
module pfph_programmer
    import pfph_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              nrst,
    pfph_if.programmer             pins,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [MODE_W-1:0] req_mode,
    input  wire logic [DATA_W-1:0] req_data,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_data
);
    pfph_prg_state_t   st_ff, nxt_st;
    logic [1:0]        rdy_sync_ff, val_sync_ff;
    logic              cmd_n_ff, nxt_cmd_n;
    logic              oe_n_ff, nxt_oe_n;
    logic              drv_ff, nxt_drv;
    logic              rd_ff, nxt_rd;
    logic [MODE_W-1:0] mode_ff, nxt_mode;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic [DATA_W-1:0] rsp_ff, nxt_rsp;
    logic              rv_ff, nxt_rv;
    logic              rdy_s, val_lo;
    // ====================
    // synchronisers for device pins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdy_sync_ff <= 2'h0;
            val_sync_ff <= 2'h3;
        end else begin
            rdy_sync_ff <= {rdy_sync_ff[0], pins.rdy};
            val_sync_ff <= {val_sync_ff[0], pins.data_valid_n};
        end
    end
    assign rdy_s  = rdy_sync_ff[1];
    assign val_lo = !val_sync_ff[1];
    // ====================
    // transaction sequencer
    always_comb begin
        nxt_st    = st_ff;
        nxt_cmd_n = cmd_n_ff;
        nxt_oe_n  = oe_n_ff;
        nxt_drv   = drv_ff;
        nxt_rd    = rd_ff;
        nxt_mode  = mode_ff;
        nxt_dout  = dout_ff;
        nxt_rsp   = rsp_ff;
        nxt_rv    = 1'b0;
        case (st_ff)
            PFPH_P_IDLE: begin
                if (req_valid && rdy_s) begin
                    nxt_mode = req_mode;
                    nxt_dout = req_data;
                    nxt_drv  = 1'b1;
                    nxt_rd   = (req_mode == MODE_READ);
                    nxt_st   = PFPH_P_SETUP;
                end
            end
            PFPH_P_SETUP: begin
                nxt_cmd_n = 1'b0;
                nxt_st    = PFPH_P_WAIT_RDY_LO;
            end
            PFPH_P_WAIT_RDY_LO: begin
                if (!rdy_s) begin
                    nxt_drv = 1'b0;
                    nxt_st  = rd_ff ? PFPH_P_OE_LO : PFPH_P_CMD_HI;
                end
            end
            PFPH_P_OE_LO: begin
                nxt_oe_n = 1'b0;
                nxt_st   = PFPH_P_WAIT_VALID_LO;
            end
            PFPH_P_WAIT_VALID_LO: begin
                if (val_lo) begin
                    nxt_rsp  = pins.data_bus;
                    nxt_rv   = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_st   = PFPH_P_WAIT_VALID_HI;
                end
            end
            PFPH_P_WAIT_VALID_HI: begin
                if (!val_lo) begin
                    nxt_st = PFPH_P_CMD_HI;
                end
            end
            PFPH_P_CMD_HI: begin
                nxt_cmd_n = 1'b1;
                nxt_st    = PFPH_P_WAIT_RDY_HI;
            end
            PFPH_P_WAIT_RDY_HI: begin
                if (rdy_s) begin
                    nxt_st = PFPH_P_IDLE;
                end
            end
            default: begin
                nxt_st = PFPH_P_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff    <= PFPH_P_IDLE;
            cmd_n_ff <= CMD_N_RST;
            oe_n_ff  <= OE_N_RST;
            drv_ff   <= 1'b0;
            rd_ff    <= 1'b0;
            mode_ff  <= '0;
            dout_ff  <= DATA_RST;
            rsp_ff   <= DATA_RST;
            rv_ff    <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            cmd_n_ff <= nxt_cmd_n;
            oe_n_ff  <= nxt_oe_n;
            drv_ff   <= nxt_drv;
            rd_ff    <= nxt_rd;
            mode_ff  <= nxt_mode;
            dout_ff  <= nxt_dout;
            rsp_ff   <= nxt_rsp;
            rv_ff    <= nxt_rv;
        end
    end
    assign pins.command_strobe_n = cmd_n_ff;
    assign pins.output_enable_n  = oe_n_ff;
    assign pins.mode             = mode_ff;
    assign pins.prg_data_o       = dout_ff;
    assign pins.prg_data_oe      = drv_ff;
    assign req_ready             = (st_ff == PFPH_P_IDLE) && rdy_s;
    assign rsp_valid             = rv_ff;
    assign rsp_data              = rsp_ff;
endmodule : pfph_programmer
`default_nettype wire

// ---- test/pfph_checker.sv ----
// assertion checker watching the programming port pins
`timescale 1ns/100ps
`default_nettype none
module pfph_checker
    import pfph_pkg::*;
(
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              command_strobe_n,
    input wire logic              output_enable_n,
    input wire logic              data_valid_n,
    input wire logic              rdy,
    input wire logic              prg_data_oe,
    input wire logic              dev_data_oe,
    input wire logic [DATA_W-1:0] dev_data_o
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ====================
    // handshake order on the pins
    // ready drops only after synchronising
    property p_rdy_drop; $fell(command_strobe_n) && rdy |-> rdy [*2] ##[1:4] !rdy; endproperty
    a_rdy_drop: assert property (p_rdy_drop) else $error("ready drop timing");
    property p_prg_off; $fell(rdy) |-> ##[1:8] !prg_data_oe; endproperty
    a_prg_off: assert property (p_prg_off) else $error("programmer kept driving");
    property p_oe_order; $fell(output_enable_n) |-> !rdy && !prg_data_oe; endproperty
    a_oe_order: assert property (p_oe_order) else $error("output enable too early");
    property p_drive_oe; $rose(dev_data_oe) |-> !output_enable_n && !command_strobe_n; endproperty
    a_drive_oe: assert property (p_drive_oe) else $error("device drove unasked");
    property p_valid_after; $fell(data_valid_n) |-> dev_data_oe && $past(dev_data_oe); endproperty
    a_valid_after: assert property (p_valid_after) else $error("valid before data");
    property p_data_hold;
        !data_valid_n && !$past(data_valid_n) |-> $stable(dev_data_o) && (dev_data_oe || output_enable_n);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved under valid");
    property p_release; $rose(output_enable_n) |-> ##[1:6] !dev_data_oe; endproperty
    a_release: assert property (p_release) else $error("bus not released");
    property p_valid_rise; $rose(data_valid_n) |-> !dev_data_oe && output_enable_n; endproperty
    a_valid_rise: assert property (p_valid_rise) else $error("valid rose while driving");
    // never two drivers on the bus
    property p_no_clash; !(prg_data_oe && dev_data_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("bus contention");
    property p_rdy_rise; $rose(rdy) |-> command_strobe_n && $past(command_strobe_n, 2); endproperty
    a_rdy_rise: assert property (p_rdy_rise) else $error("ready rose early");
endmodule : pfph_checker
`default_nettype wire

// ---- test/tb.sv ----
// bench joining programmer and device ends
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pfph_pkg::*;
    logic              mclk;
    logic              nrst;
    logic              req_valid;
    logic              req_ready;
    logic [MODE_W-1:0] req_mode;
    logic [DATA_W-1:0] req_data;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic              cmd_valid;
    logic [MODE_W-1:0] cmd_mode;
    logic [DATA_W-1:0] cmd_data;
    logic              cmd_done;
    logic              rd_valid;
    logic              rd_ready;
    logic [DATA_W-1:0] rd_data;
    int                bad_count;
    int                check_count;
    logic [DATA_W-1:0] exp_q[$];
    // ====================
    // ends, pins and checker
    pfph_if u_pfph_if ();
    pfph_programmer u_pfph_programmer (.mclk(mclk), .nrst(nrst), .pins(u_pfph_if), .req_valid(req_valid),
        .req_ready(req_ready), .req_mode(req_mode), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    pfph_device u_pfph_device (.mclk(mclk), .nrst(nrst), .pins(u_pfph_if), .cmd_valid(cmd_valid),
        .cmd_mode(cmd_mode), .cmd_data(cmd_data), .cmd_done(cmd_done), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data));
    pfph_checker u_pfph_checker (.mclk(mclk), .nrst(nrst), .command_strobe_n(u_pfph_if.command_strobe_n),
        .output_enable_n(u_pfph_if.output_enable_n), .data_valid_n(u_pfph_if.data_valid_n), .rdy(u_pfph_if.rdy),
        .prg_data_oe(u_pfph_if.prg_data_oe), .dev_data_oe(u_pfph_if.dev_data_oe), .dev_data_o(u_pfph_if.dev_data_o));
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // ====================
    // compares and helpers
    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t word %h want %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_mode(input logic [MODE_W-1:0] got, input logic [MODE_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t mode %h want %h", $time, got, exp);
        end
    endtask : chk_mode
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t flag %b want %b", $time, got, exp);
        end
    endtask : chk_flag
    function automatic logic [DATA_W-1:0] rnd_word();
        return DATA_W'($urandom);
    endfunction : rnd_word
    // any mode but read is a write
    function automatic logic [MODE_W-1:0] wr_mode(input logic [MODE_W-1:0] m);
        return (m == MODE_READ) ? m + 4'h1 : m;
    endfunction : wr_mode
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    // bounded wait: 0 req_ready, 1 rsp_valid, 2 cmd_valid, 3 rd_ready
    task automatic wait_on(input int k);
        int n;
        n = 0;
        while (!(k == 0 ? req_ready === 1'h1 : k == 1 ? rsp_valid === 1'h1 :
                 k == 2 ? cmd_valid === 1'h1 : rd_ready === 1'h1) && n < 500) begin
            step(1);
            n++;
        end
        if (n >= 500) begin
            bad_count++;
            $display("[FAIL] %0t wait %0d timed out", $time, k);
            stop_test();
        end
    endtask : wait_on
    task automatic push(input logic [DATA_W-1:0] d);
        rd_valid = 1'h1;
        rd_data = d;
        wait_on(3);
        step(1);
        rd_valid = 1'h0;
        exp_q.push_back(d);
        // one edge with valid low before any next push
        step(1);
    endtask : push
    task automatic send_req(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] d);
        req_valid = 1'h1;
        req_mode = m;
        req_data = d;
        wait_on(0);
        step(1);
        req_valid = 1'h0;
    endtask : send_req
    task automatic do_read();
        send_req(MODE_READ, rnd_word());
        wait_on(1);
        chk_word(rsp_data, exp_q.pop_front());
    endtask : do_read
    task automatic do_write(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] d, input int hold);
        send_req(m, d);
        wait_on(2);
        chk_mode(cmd_mode, m);
        chk_word(cmd_data, d);
        step(hold);
        chk_flag(u_pfph_if.rdy, 1'h0);
        chk_flag(u_pfph_if.dev_data_oe, 1'h0);
        cmd_done = 1'h1;
        step(1);
        cmd_done = 1'h0;
        wait_on(0);
        chk_flag(cmd_valid, 1'h0);
        chk_flag(u_pfph_if.command_strobe_n, 1'h1);
    endtask : do_write
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // ====================
    // watchdog
    initial begin
        #300000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
    // ====================
    // main sequence
    initial begin
        {mclk, nrst, req_valid, cmd_done, rd_valid} = 5'h00;
        {req_mode, req_data, rd_data} = 36'h0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(8212));
        step(16);
        nrst = 1'h1;
        step(4);
        chk_flag(u_pfph_if.rdy, RDY_RST);
        chk_flag(u_pfph_if.data_valid_n, VALID_N_RST);
        // fill buffer until it refuses, corner words first
        push(16'h0000);
        push(16'hffff);
        repeat (FIFO_DEPTH - 2) push(rnd_word());
        chk_flag(rd_ready, 1'h0);
        repeat (FIFO_DEPTH) do_read();
        chk_flag(rd_ready, 1'h1);
        // every write mode
        for (int i = 0; i < 16; i++) begin
            if (i[MODE_W-1:0] != MODE_READ) do_write(i[MODE_W-1:0], rnd_word(), 1 + $urandom_range(19));
        end
        // random mix of reads and writes
        for (int i = 0; i < 24; i++) begin
            if ($urandom_range(1) == 1) begin
                push(rnd_word());
                do_read();
            end else begin
                do_write(wr_mode(MODE_W'($urandom)), rnd_word(), 1 + $urandom_range(7));
            end
        end
        // read against an empty buffer stalls before valid
        send_req(MODE_READ, rnd_word());
        step(40);
        chk_flag(rsp_valid, 1'h0);
        chk_flag(u_pfph_if.data_valid_n, 1'h1);
        push(rnd_word());
        wait_on(1);
        chk_word(rsp_data, exp_q.pop_front());
        // reset in mid-read while the device drives, then recover
        push(rnd_word());
        send_req(MODE_READ, rnd_word());
        step(14);
        chk_flag(u_pfph_if.dev_data_oe, 1'h1);
        nrst = 1'h0;
        exp_q.delete();
        step(2);
        chk_flag(u_pfph_if.rdy, RDY_RST);
        chk_flag(u_pfph_if.dev_data_oe, 1'h0);
        chk_flag(u_pfph_if.data_valid_n, VALID_N_RST);
        nrst = 1'h1;
        step(2);
        push(rnd_word());
        do_read();
        step(20);
        stop_test();
    end
endmodule : tb
`default_nettype wire
